/* File: rtl/pds_top.sv */
// divider input select, prescaler, divider chain and three-wire serial port
// assumes all pins are asynchronous and slow against sys_clk_i
// Function
// - select bit 1 feeds the high-band input into the divider chain.
// - high band passes a divide-by-two prescaler, so the total ratio is twice the setting.
// - select bit 0 feeds the low-band input into the divider chain instead.
// - low band with mode bit 1 drives the swallow counter directly at the set ratio.
// - low band with mode bit 0 drives a 12-bit direct divider at the set ratio.
// - the controller's serial clock times every input bit and every output bit after the first, which enable rise presents.
// - control bits arrive on the serial input line as configuration data.
// - the serial output line returns the word chosen by the output content select field.
// - reset puts all logic into a defined state before any configuration arrives.
// - an eight-bit address before each transfer picks input mode one, two or output.
// - each input mode takes exactly twenty-four data bits after the address.
// - output mode shifts one bit per serial clock for as long as clocks come.
`timescale 1ns/100ps
module pds_top
  import pds_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        enable_line_i,
  input  wire logic        serial_clock_line_i,
  input  wire logic        serial_input_line_i,
  input  wire logic        high_band_lo_input_i,
  input  wire logic        low_band_lo_input_i,
  output logic             serial_output_line_o,
  output logic             serial_output_oe_b_o,
  output logic             divided_o,
  output logic             divider_input_select_o,
  output logic             low_band_divider_mode_o,
  output logic [15:0]      divisor_o
);

  logic [PDS_PIN_N-1:0]  pin_w;
  logic [PDS_PIN_N-1:0]  meta_r;
  logic [PDS_PIN_N-1:0]  sync_r;
  logic [PDS_PIN_N-1:0]  dly_r;
  logic [PDS_PIN_N-1:0]  rise_w;
  logic [PDS_PIN_N-1:0]  fall_w;

  logic                  ce_w;
  logic                  di_w;
  logic                  ce_rise_w;
  logic                  ce_fall_w;
  logic                  cl_rise_w;
  logic                  cl_fall_w;

  pds_mode_e             mode_r;
  pds_mode_e             mode_nxt;
  pds_mode_e             addr_mode_w;
  logic [7:0]            addr_r;
  logic [PDS_CNT_W-1:0]  cnt_r;
  logic [23:0]           shift_r;
  logic [23:0]           in1_r;
  logic [23:0]           in2_r;
  logic [23:0]           out_r;
  logic [23:0]           out_word_w;
  logic [23:0]           ticks_r;
  logic                  in_mode_w;
  logic                  take_bit_w;
  logic                  commit_w;
  logic [2:0]            ocs_w;

  pds_cfg_s              cfg_w;
  logic                  pres_r;
  logic                  pres_pulse_w;
  logic                  sw_pulse_w;
  logic                  dir_pulse_w;
  logic                  sw_tick_w;
  logic                  dir_tick_w;
  logic                  div_nxt;
  logic [15:0]           sw_ratio_w;
  logic [11:0]           dir_ratio_w;

  // two-stage synchronisers, edges taken from the second stage only
  assign pin_w[PDS_PIN_CE] = enable_line_i;
  assign pin_w[PDS_PIN_CL] = serial_clock_line_i;
  assign pin_w[PDS_PIN_DI] = serial_input_line_i;
  assign pin_w[PDS_PIN_HB] = high_band_lo_input_i;
  assign pin_w[PDS_PIN_LB] = low_band_lo_input_i;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      sync_r <= '0;
      dly_r  <= '0;
    end else begin
      meta_r <= pin_w;
      sync_r <= meta_r;
      dly_r  <= sync_r;
    end
  end

  assign rise_w    = sync_r & ~dly_r;
  assign fall_w    = ~sync_r & dly_r;
  assign ce_w      = sync_r[PDS_PIN_CE];
  assign di_w      = sync_r[PDS_PIN_DI];
  assign ce_rise_w = rise_w[PDS_PIN_CE];
  assign ce_fall_w = fall_w[PDS_PIN_CE];
  // serial clock rise times each input bit and its fall each output bit after the first, which enable rise sets up
  assign cl_rise_w = rise_w[PDS_PIN_CL];
  assign cl_fall_w = fall_w[PDS_PIN_CL];

  // address decode taken at enable rise; unknown addresses stay idle
  assign addr_mode_w = (addr_r == PDS_ADDR_IN1) ? PDS_IN1 :
                       (addr_r == PDS_ADDR_IN2) ? PDS_IN2 :
                       (addr_r == PDS_ADDR_OUT) ? PDS_OUT : PDS_IDLE;

  // enable fall always ends the transfer, so a short frame cannot linger
  assign mode_nxt = ce_fall_w ? PDS_IDLE :
                    ce_rise_w ? addr_mode_w : mode_r;

  always_comb begin
    in_mode_w = 1'b0;
    unique case (mode_r)
      PDS_IDLE: in_mode_w = 1'b0;
      PDS_IN1:  in_mode_w = 1'b1;
      PDS_IN2:  in_mode_w = 1'b1;
      PDS_OUT:  in_mode_w = 1'b0;
    endcase
  end

  // bits past the 24th are ignored rather than shifting the word
  assign take_bit_w = in_mode_w && ce_w && cl_rise_w && (cnt_r < PDS_FRAME_BITS);
  assign commit_w   = ce_fall_w && in_mode_w && (cnt_r == PDS_FRAME_BITS);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      mode_r <= PDS_IDLE;
      addr_r <= PDS_ADDR_RST;
    end else begin
      mode_r <= mode_nxt;
      if (!ce_w && cl_rise_w) begin
        addr_r <= {di_w, addr_r[7:1]};
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cnt_r   <= '0;
      shift_r <= PDS_WORD_RST;
    end else if (ce_rise_w) begin
      cnt_r   <= '0;
    end else if (take_bit_w) begin
      cnt_r   <= cnt_r + 5'h01;
      shift_r <= {di_w, shift_r[23:1]};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      in1_r <= PDS_WORD_RST;
      in2_r <= PDS_WORD_RST;
    end else if (commit_w) begin
      if (mode_r == PDS_IN1) begin
        in1_r <= shift_r;
      end else begin
        in2_r <= shift_r;
      end
    end
  end

  // output word chosen by the content select field of input word two
  assign ocs_w      = in2_r[PDS_OCS_LSB +: 3];
  assign out_word_w = (ocs_w == PDS_OCS_IN1)   ? in1_r :
                      (ocs_w == PDS_OCS_IN2)   ? in2_r :
                      (ocs_w == PDS_OCS_TICKS) ? ticks_r : PDS_WORD_RST;

  // first bit stands from enable rise, later bits move on each clock fall
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      out_r <= PDS_WORD_RST;
    end else if (ce_rise_w && (addr_mode_w == PDS_OUT)) begin
      out_r <= out_word_w;
    end else if ((mode_r == PDS_OUT) && cl_fall_w) begin
      out_r <= {1'b0, out_r[23:1]};
    end
  end

  // idle level is high so the released line and the driven line agree
  assign serial_output_line_o = (mode_r == PDS_OUT) ? out_r[0] : 1'b1;
  assign serial_output_oe_b_o = (mode_r != PDS_OUT);

  // divider chain
  assign cfg_w.divisor               = in1_r[PDS_DIVISOR_LSB +: 16];
  assign cfg_w.divider_input_select  = in1_r[PDS_SEL_BIT];
  assign cfg_w.low_band_divider_mode = in1_r[PDS_MODE_BIT];

  assign divisor_o               = cfg_w.divisor;
  assign divider_input_select_o  = cfg_w.divider_input_select;
  assign low_band_divider_mode_o = cfg_w.low_band_divider_mode;

  // settings under the documented minimum are clamped to it
  assign sw_ratio_w  = (cfg_w.divisor < PDS_SWALLOW_MIN) ? PDS_SWALLOW_MIN : cfg_w.divisor;
  assign dir_ratio_w = (cfg_w.divisor[11:0] < PDS_DIRECT_MIN) ? PDS_DIRECT_MIN
                                                               : cfg_w.divisor[11:0];

  assign pres_pulse_w = rise_w[PDS_PIN_HB] && pres_r;
  assign sw_pulse_w   = cfg_w.divider_input_select ? pres_pulse_w :
                        (cfg_w.low_band_divider_mode && rise_w[PDS_PIN_LB]);
  assign dir_pulse_w  = !cfg_w.divider_input_select && !cfg_w.low_band_divider_mode &&
                        rise_w[PDS_PIN_LB];
  assign div_nxt      = (cfg_w.divider_input_select || cfg_w.low_band_divider_mode) ?
                        sw_tick_w : dir_tick_w;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pres_r    <= 1'b0;
      divided_o <= 1'b0;
      ticks_r   <= PDS_WORD_RST;
    end else begin
      if (rise_w[PDS_PIN_HB]) begin
        pres_r <= ~pres_r;
      end
      divided_o <= div_nxt;
      if (div_nxt) begin
        ticks_r <= ticks_r + 24'h000001;
      end
    end
  end

  pds_div #(
    .W         (PDS_SWALLOW_W)
  ) u_swallow (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .pulse_i   (sw_pulse_w),
    .ratio_i   (sw_ratio_w),
    .tick_o    (sw_tick_w)
  );

  pds_div #(
    .W         (PDS_DIRECT_W)
  ) u_direct (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .pulse_i   (dir_pulse_w),
    .ratio_i   (dir_ratio_w),
    .tick_o    (dir_tick_w)
  );

endmodule : pds_top

/* File: rtl/pds_pkg.sv */
// constants, modes and the control word layout of the divider select block
// assumes a 100 MHz system clock that oversamples every pin
package pds_pkg;

  localparam int          PDS_SYS_CLK_MHZ  = 100;
  localparam int          PDS_ADDR_W       = 8;
  localparam int          PDS_WORD_W       = 24;
  localparam int          PDS_CNT_W        = 5;
  localparam logic [4:0]  PDS_FRAME_BITS   = 5'h18;
  localparam int          PDS_SWALLOW_W    = 16;
  localparam int          PDS_DIRECT_W     = 12;
  localparam int          PDS_PIN_N        = 5;

  // address bytes as shifted in, first bit into bit 0
  localparam logic [7:0]  PDS_ADDR_IN1     = 8'h28;
  localparam logic [7:0]  PDS_ADDR_IN2     = 8'h29;
  localparam logic [7:0]  PDS_ADDR_OUT     = 8'h2a;

  localparam logic [15:0] PDS_SWALLOW_MIN  = 16'h0110;
  localparam logic [11:0] PDS_DIRECT_MIN   = 12'h004;

  // field positions inside the 24-bit words
  localparam int          PDS_DIVISOR_LSB  = 0;
  localparam int          PDS_SEL_BIT      = 16;
  localparam int          PDS_MODE_BIT     = 17;
  localparam int          PDS_OCS_LSB      = 0;

  localparam logic [23:0] PDS_WORD_RST     = 24'h000000;
  localparam logic [7:0]  PDS_ADDR_RST     = 8'h00;

  // output content select codes
  localparam logic [2:0]  PDS_OCS_IN1      = 3'h0;
  localparam logic [2:0]  PDS_OCS_IN2      = 3'h1;
  localparam logic [2:0]  PDS_OCS_TICKS    = 3'h2;

  // pin order in the synchroniser vector
  localparam int          PDS_PIN_CE       = 0;
  localparam int          PDS_PIN_CL       = 1;
  localparam int          PDS_PIN_DI       = 2;
  localparam int          PDS_PIN_HB       = 3;
  localparam int          PDS_PIN_LB       = 4;

  typedef enum logic [3:0] {
    PDS_IDLE = 4'h1,
    PDS_IN1  = 4'h2,
    PDS_IN2  = 4'h4,
    PDS_OUT  = 4'h8
  } pds_mode_e;

  typedef struct packed {
    logic [15:0] divisor;
    logic        divider_input_select;
    logic        low_band_divider_mode;
  } pds_cfg_s;

endpackage : pds_pkg

/* File: rtl/pds_div.sv */
// programmable counter: one tick per ratio_i input pulses
// assumes input pulses are one system clock wide and ratio_i is at least 1
`timescale 1ns/100ps
module pds_div #(
  parameter int W = 16
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         pulse_i,
  input  wire logic [W-1:0] ratio_i,
  output logic              tick_o
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] last_w;
  logic         wrap_w;

  // compare with >= so a ratio lowered mid-count still wraps
  assign last_w = ratio_i - {{(W-1){1'b0}}, 1'b1};
  assign wrap_w = pulse_i && (cnt_r >= last_w);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= wrap_w;
      if (wrap_w) begin
        cnt_r <= '0;
      end else if (pulse_i) begin
        cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule : pds_div

/* File: verif/pds_top_asserts.sv */
// checker for the divider select block, bound into pds_top
// assumes pins change slowly against sys_clk_i
`timescale 1ns/100ps
module pds_top_asserts (
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic        enable_line_i,
  input wire logic        serial_clock_line_i,
  input wire logic        serial_input_line_i,
  input wire logic        high_band_lo_input_i,
  input wire logic        low_band_lo_input_i,
  input wire logic        serial_output_line_o,
  input wire logic        serial_output_oe_b_o,
  input wire logic        divided_o,
  input wire logic        divider_input_select_o,
  input wire logic        low_band_divider_mode_o,
  input wire logic [15:0] divisor_o
);
  logic       cl_r;
  logic [3:0] fall_age_r;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // cycles since the clock pin fell, saturating so a long idle never wraps
  always_ff @(posedge sys_clk_i) begin
    cl_r <= serial_clock_line_i;
    if (!rst_b_i) fall_age_r <= 4'hf;
    else if (cl_r && !serial_clock_line_i) fall_age_r <= 4'h0;
    else if (fall_age_r != 4'hf) fall_age_r <= fall_age_r + 4'h1;
  end
  a_reset_vals: assert property ($rose(rst_b_i) |-> serial_output_oe_b_o
    && serial_output_line_o && !divided_o && divisor_o == 16'h0000)
    else $error("outputs not at reset values");
  a_do_idle_high: assert property (serial_output_oe_b_o |-> serial_output_line_o)
    else $error("released data out not high");
  a_oe_drop_ce: assert property ($fell(enable_line_i) |-> ##[1:6] serial_output_oe_b_o)
    else $error("data out driven after enable fell");
  a_oe_after_ce: assert property ($fell(serial_output_oe_b_o) |-> $past(enable_line_i, 2))
    else $error("data out driven without enable");
  a_cfg_after_fall: assert property ($changed({divisor_o, divider_input_select_o,
    low_band_divider_mode_o}) |-> !$past(enable_line_i))
    else $error("config changed while enable high");
  a_cfg_quiet_ce: assert property (enable_line_i [*8] |-> $stable(divisor_o))
    else $error("divisor moved during a transfer");
  a_div_one_pulse: assert property (divided_o |=> !divided_o)
    else $error("divider output wider than one cycle");
  a_div_spacing: assert property (divided_o |=> !divided_o [*8])
    else $error("divider pulses too close");
  a_do_on_clfall: assert property (!serial_output_oe_b_o && !$past(serial_output_oe_b_o)
    && !$past(serial_output_oe_b_o, 2) && $changed(serial_output_line_o) |-> fall_age_r <= 4'h6)
    else $error("data out moved without a clock fall");
  c_read: cover property ($fell(serial_output_oe_b_o));
  c_commit: cover property ($changed(divisor_o));
  c_high_band: cover property (divided_o && divider_input_select_o);
endmodule : pds_top_asserts
bind pds_top pds_top_asserts u_chk (
  .sys_clk_i, .rst_b_i, .enable_line_i, .serial_clock_line_i, .serial_input_line_i,
  .high_band_lo_input_i, .low_band_lo_input_i, .serial_output_line_o, .serial_output_oe_b_o,
  .divided_o, .divider_input_select_o, .low_band_divider_mode_o, .divisor_o
);

/* File: verif/pds_ctrl_model.sv */
// system controller model driving enable, clock and data in of the divider block
// assumes frames are requested one at a time; its clock stands still between frames
`timescale 1ns/100ps
module pds_ctrl_model (
  input  wire logic serial_output_line_i,
  input  wire logic serial_output_oe_b_i,
  output logic      enable_line_o,
  output logic      serial_clock_line_o,
  output logic      serial_input_line_o
);
  initial begin
    enable_line_o = 1'b0;
    serial_clock_line_o = 1'b0;
    serial_input_line_o = 1'b0;
  end
  // one 80 ns bit; data in flips once its hold is over, undriven data out reads unknown
  task automatic clk_bit(input logic b, output logic q);
    serial_input_line_o = b;
    #20 serial_clock_line_o = 1'b1;
    #35 q = serial_output_oe_b_i ? 1'bx : serial_output_line_i;
    #5 serial_clock_line_o = 1'b0;
    serial_input_line_o = ~b;
    #20;
  endtask : clk_bit
  task automatic frame(input logic [7:0] a, input logic [23:0] w, input int n,
                       output logic [23:0] rd);
    logic q;
    rd = 24'h000000;
    enable_line_o = 1'b0;
    #40;
    for (int i = 0; i < 8; i++) clk_bit(a[i], q);
    enable_line_o = 1'b1;
    #60;
    for (int i = 0; i < n; i++) begin
      clk_bit(w[i % 24], q);
      if (i < 24) rd[i] = q;
    end
    #20 enable_line_o = 1'b0;
    #80;
  endtask : frame
endmodule : pds_ctrl_model

/* File: verif/pds_top_tb_top.sv */
// self-checking bench for pds_top
// assumes the controller model owns enable, clock and data in; bench makes both lo inputs
`timescale 1ns/100ps
module pds_top_tb_top;
  import pds_pkg::*;
  logic        sys_clk_i, rst_b_i, enable_line_i, serial_clock_line_i, serial_input_line_i;
  logic        high_band_lo_input_i, low_band_lo_input_i, serial_output_line_o;
  logic        serial_output_oe_b_o, divided_o, divider_input_select_o, low_band_divider_mode_o;
  logic [15:0] divisor_o;
  logic [23:0] cfg;
  logic [23:0] rd, tick_cnt, tick_snap, tick_held;
  int          mismatches, num_checks, cyc;
  assign cfg = {6'h00, low_band_divider_mode_o, divider_input_select_o, divisor_o};
  pds_top DUT (
    .sys_clk_i, .rst_b_i, .enable_line_i, .serial_clock_line_i, .serial_input_line_i,
    .high_band_lo_input_i, .low_band_lo_input_i, .serial_output_line_o, .serial_output_oe_b_o,
    .divided_o, .divider_input_select_o, .low_band_divider_mode_o, .divisor_o
  );
  pds_ctrl_model u_ctrl (
    .serial_output_line_i(serial_output_line_o),
    .serial_output_oe_b_i(serial_output_oe_b_o),
    .enable_line_o       (enable_line_i),
    .serial_clock_line_o (serial_clock_line_i),
    .serial_input_line_o (serial_input_line_i)
  );
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic t_reset_state;
    check({6'h00, divisor_o, divider_input_select_o, serial_output_oe_b_o}, 24'h000001);
  endtask : t_reset_state
  // one good commit, short and foreign frames that are dropped, then an overlong frame that commits its first 24 bits
  task automatic t_commit;
    u_ctrl.frame(PDS_ADDR_IN1, 24'h010110, 24, rd);
    check(cfg, 24'h010110);
    u_ctrl.frame(PDS_ADDR_IN1, 24'h02abcd, 23, rd);
    check(cfg, 24'h010110);
    u_ctrl.frame(8'h55, 24'h02abcd, 24, rd);
    check(cfg, 24'h010110);
    u_ctrl.frame(PDS_ADDR_IN1, 24'hf2abcd, 26, rd);
    check(cfg, 24'h02abcd);
  endtask : t_commit
  // first two intervals may straddle the config change, so the third is kept
  task automatic ratio(input logic [23:0] w, output int n);
    u_ctrl.frame(PDS_ADDR_IN1, w, 24, rd);
    repeat (3) begin
      n = 0;
      do begin
        @(posedge sys_clk_i);
        #1 n++;
      end while (divided_o !== 1'b1 && n < 8000);
    end
  endtask : ratio
  task automatic t_ratios;
    int n;
    ratio(24'h010110, n);
    check(24'(n), 24'(2 * 272 * 6));
    ratio(24'h020110, n);
    check(24'(n), 24'(272 * 8));
    ratio(24'h000005, n);
    check(24'(n), 24'(5 * 8));
    ratio(24'h000003, n);
    check(24'(n), 24'(4 * 8));
  endtask : t_ratios
  task automatic t_readback;
    u_ctrl.frame(PDS_ADDR_IN2, {21'h000000, PDS_OCS_IN1}, 24, rd);
    u_ctrl.frame(PDS_ADDR_OUT, 24'h000000, 30, rd);
    check(rd, 24'h000003);
    u_ctrl.frame(PDS_ADDR_IN2, 24'h5a5001, 24, rd);
    u_ctrl.frame(PDS_ADDR_OUT, 24'h000000, 24, rd);
    check(rd, 24'h5a5001);
    u_ctrl.frame(PDS_ADDR_IN2, {21'h000000, PDS_OCS_TICKS}, 24, rd);
    u_ctrl.frame(PDS_ADDR_OUT, 24'h000000, 24, rd);
    check(rd, tick_held);
    u_ctrl.frame(PDS_ADDR_IN2, 24'h000003, 24, rd);
    u_ctrl.frame(PDS_ADDR_OUT, 24'h000000, 24, rd);
    check(rd, 24'h000000);
    check({22'h000000, serial_output_oe_b_o, serial_output_line_o}, 24'h000003);
  endtask : t_readback
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // lo inputs: high band every 6 cycles, low band every 8
  always begin
    repeat (3) @(posedge sys_clk_i);
    #1 high_band_lo_input_i = ~high_band_lo_input_i;
  end
  always begin
    repeat (4) @(posedge sys_clk_i);
    #1 low_band_lo_input_i = ~low_band_lo_input_i;
  end
  // pulse count mirror; the copy taken last before data out is driven is what gets shifted
  always @(posedge sys_clk_i) begin
    #1;
    if (divided_o === 1'b1) tick_cnt = tick_cnt + 24'h000001;
    if (serial_output_oe_b_o === 1'b1) tick_snap = tick_cnt;
    else tick_held = tick_snap;
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      complete_run;
    end
  end
  initial begin
    rst_b_i = 1'b0;
    high_band_lo_input_i = 1'b0;
    low_band_lo_input_i = 1'b0;
    mismatches = 0;
    num_checks = 0;
    cyc = 0;
    tick_cnt = 24'h000000;
    repeat (8) @(posedge sys_clk_i);
    #1 rst_b_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1 t_reset_state;
    t_commit;
    t_ratios;
    t_readback;
    complete_run;
  end
endmodule : pds_top_tb_top
